// ### core/abx_alu.sv
// Eight-bit adder, subtractor and logic unit with flag outputs.
// Purely combinational; the caller decides which flags it keeps.
`timescale 1ns/1ns
module abx_alu (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic ci,
   input wire abx_pkg::abx_alusel_e sel,
   output logic [7:0] res,
   output abx_pkg::abx_flags_s fl
);
   import abx_pkg::*;

   logic [8:0] sum;

   always_comb begin
      sum = 9'h000;
      res = 8'h00;
      fl = '0;
      case (sel)
         ALU_ADD: begin
            sum = {1'b0, a} + {1'b0, b} + {8'h00, ci};
            res = sum[7:0];
            fl.c = sum[8];
            fl.h = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
            fl.v = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
         end
         ALU_SUB: begin
            sum = {1'b0, a} - {1'b0, b} - {8'h00, ci};
            res = sum[7:0];
            fl.c = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
            fl.h = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
            fl.v = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
         end
         ALU_AND: res = a & b;
         ALU_OR: res = a | b;
         ALU_XOR: res = a ^ b;
         default: res = 8'h00;
      endcase
      fl.n = res[7];
      fl.z = (res == 8'h00);
   end

endmodule // abx_alu

// ### core/abx_core.sv
// ALU and conditional branch execute unit with AHB-Lite register port.
// Assumes one slave on the bus, so HREADY is this block's HREADYOUT.
//
// Notes on behaviour
// - Add source to destination, plus carry if asked; all five flags.
// - Subtract source, minus carry if asked, from destination; five flags.
// - Subtract immediate, with or without carry, from destination.
// - Compares set five flags only, write no register, take one cycle.
// - AND, OR, XOR write back; update Z, N, V; keep C and H.
// - Mask clear ANDs with complement of constant; mask set ORs it.
// - Test ANDs register with itself, keeps it, sets Z, N, V.
// - Equal skip jumps over next instruction; one or two cycles.
// - Register bit skips test a register bit for zero or one.
// - I/O bit skips test an I/O register bit for zero or one.
// - Status bit jumps test status bit by index; load PC+k+1.
// - Conditional jumps take one cycle untaken, two taken; no flags.
// - Signed jumps use N xor V: zero for GE, one for less.
// - Unsigned jumps use carry alone: zero for GE, one for lower.
// - Carry, zero and negative jumps taken when flag matches.
// - Jump pairs on half-carry, copy flag and overflow flag.
// - Jumps on interrupt enable flag; the flag itself is untouched.
`timescale 1ns/1ns
module abx_core (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP
);
   import abx_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HOLD} abx_state_e;

   logic [DATA_W-1:0] rf_q [RF_N];
   logic [7:0] flags_q;
   logic [7:0] io_q;
   logic [PC_W-1:0] pc_q;
   logic [DISP_W-1:0] disp_q;
   abx_cmd_s cmd_q;
   abx_state_e state_q;
   logic [1:0] last_q;
   logic act_q;
   logic wr_q;
   logic [5:0] widx_q;
   logic rd_rdy_q;
   logic [31:0] hrdata_q;

   logic busy;
   logic wr_go;
   logic rd_go;
   logic [31:0] rd_val;
   logic [7:0] opa;
   logic [7:0] opr;
   logic [7:0] opb;
   logic [7:0] alu_res;
   abx_flags_s alu_fl;
   abx_alusel_e alu_sel;
   logic use_imm;
   logic use_c;
   logic wb;
   logic arith;
   logic logic_op;
   logic is_skip;
   logic is_jump;
   logic cond;
   logic taken;
   logic [PC_W-1:0] pc_next;
   logic [7:0] flags_next;
   logic exec;

   // Named jump conditions, each a fixed flag and polarity; the signed pair uses N xor V
   function automatic logic jump_test(input logic [5:0] op,
                                      input logic [7:0] s);
      logic t;
      t = 1'b0;
      case (op)
         OP_EQUAL_JUMP: t = s[FLG_Z];
         OP_UNEQUAL_JUMP: t = ~s[FLG_Z];
         OP_CARRY_ONE_JUMP: t = s[FLG_C];
         OP_CARRY_ZERO_JUMP: t = ~s[FLG_C];
         OP_UNSIGNED_GE_JUMP: t = ~s[FLG_C];
         OP_UNSIGNED_LESS_JUMP: t = s[FLG_C];
         OP_NEGATIVE_JUMP: t = s[FLG_N];
         OP_POSITIVE_JUMP: t = ~s[FLG_N];
         OP_SIGNED_GE_JUMP: t = ~(s[FLG_N] ^ s[FLG_V]);
         OP_SIGNED_LESS_JUMP: t = s[FLG_N] ^ s[FLG_V];
         OP_HALFCARRY_ONE_JUMP: t = s[FLG_H];
         OP_HALFCARRY_ZERO_JUMP: t = ~s[FLG_H];
         OP_COPYFLAG_ONE_JUMP: t = s[FLG_T];
         OP_COPYFLAG_ZERO_JUMP: t = ~s[FLG_T];
         OP_OVERFLOW_ONE_JUMP: t = s[FLG_V];
         OP_OVERFLOW_ZERO_JUMP: t = ~s[FLG_V];
         OP_IRQ_ENABLED_JUMP: t = s[FLG_I];
         OP_IRQ_DISABLED_JUMP: t = ~s[FLG_I];
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   function automatic logic [PC_W-1:0] pc_add(input logic [PC_W-1:0] p,
                                              input logic [PC_W-1:0] d);
      return p + d;
   endfunction

   assign busy = (state_q != ST_IDLE);
   assign exec = CE & (state_q == ST_EXEC);
   assign wr_go = CE & act_q & wr_q & ~busy;
   assign rd_go = CE & act_q & ~wr_q & ~busy & ~rd_rdy_q;
   assign HREADYOUT = CE & (~act_q | (wr_q ? ~busy : rd_rdy_q));
   assign HRDATA = hrdata_q;
   assign HRESP = 1'b0;

   // Bus address phase capture
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         act_q <= 1'b0;
         wr_q <= 1'b0;
         widx_q <= 6'h00;
      end else if (CE && HREADY) begin
         act_q <= HSEL & HTRANS[1];
         wr_q <= HWRITE;
         widx_q <= HADDR[7:2];
      end
   end

   // Read data, one wait state when idle, more while an instruction executes
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rd_rdy_q <= 1'b0;
         hrdata_q <= 32'h0000_0000;
      end else if (CE) begin
         rd_rdy_q <= rd_go;
         if (rd_go) begin
            hrdata_q <= rd_val;
         end
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      if (widx_q[IDX_RF_BIT]) begin
         rd_val = {24'h00_0000, rf_q[widx_q[4:0]]};
      end else begin
         case (widx_q)
            IDX_CMD: rd_val = {4'h0, cmd_q};
            IDX_DISP: rd_val = {25'h000_0000, disp_q};
            IDX_FLAGS: rd_val = {24'h00_0000, flags_q};
            IDX_PC: rd_val = {22'h00_0000, pc_q};
            IDX_STAT: rd_val = {29'h0000_0000, last_q, busy};
            IDX_IO: rd_val = {24'h00_0000, io_q};
            default: rd_val = 32'h0000_0000;
         endcase
      end
   end

   // Operation decode
   always_comb begin
      alu_sel = ALU_ADD;
      use_imm = 1'b0;
      use_c = 1'b0;
      wb = 1'b0;
      arith = 1'b0;
      logic_op = 1'b0;
      case (cmd_q.op)
         OP_ADD, OP_ADC: begin
            arith = 1'b1;
            wb = 1'b1;
            use_c = (cmd_q.op == OP_ADC);
         end
         OP_SUB, OP_BORROW_REGISTER_DIFFERENCE: begin
            alu_sel = ALU_SUB;
            arith = 1'b1;
            wb = 1'b1;
            use_c = (cmd_q.op == OP_BORROW_REGISTER_DIFFERENCE);
         end
         OP_IMMEDIATE_DIFFERENCE, OP_IMMEDIATE_BORROW_DIFFERENCE: begin
            alu_sel = ALU_SUB;
            arith = 1'b1;
            wb = 1'b1;
            use_imm = 1'b1;
            use_c = (cmd_q.op == OP_IMMEDIATE_BORROW_DIFFERENCE);
         end
         OP_FLAG_ONLY_COMPARE, OP_CARRY_COMPARE, OP_IMMEDIATE_COMPARE: begin
            alu_sel = ALU_SUB;
            arith = 1'b1;
            use_imm = (cmd_q.op == OP_IMMEDIATE_COMPARE);
            use_c = (cmd_q.op == OP_CARRY_COMPARE);
         end
         OP_AND, OP_CONSTANT_CONJUNCTION: begin
            alu_sel = ALU_AND;
            logic_op = 1'b1;
            wb = 1'b1;
            use_imm = (cmd_q.op == OP_CONSTANT_CONJUNCTION);
         end
         OP_OR, OP_CONSTANT_DISJUNCTION: begin
            alu_sel = ALU_OR;
            logic_op = 1'b1;
            wb = 1'b1;
            use_imm = (cmd_q.op == OP_CONSTANT_DISJUNCTION);
         end
         OP_EXCLUSIVE_DISJUNCTION: begin
            alu_sel = ALU_XOR;
            logic_op = 1'b1;
            wb = 1'b1;
         end
         OP_MASK_BIT_CLEAR: begin
            alu_sel = ALU_AND;
            logic_op = 1'b1;
            wb = 1'b1;
         end
         OP_MASK_BIT_SET: begin
            alu_sel = ALU_OR;
            logic_op = 1'b1;
            wb = 1'b1;
            use_imm = 1'b1;
         end
         OP_SELF_CONJUNCTION_CHECK: begin
            alu_sel = ALU_AND;
            logic_op = 1'b1;
         end
         default: alu_sel = ALU_ADD;
      endcase
   end

   assign opa = rf_q[cmd_q.dst];
   assign opr = rf_q[cmd_q.src];

   always_comb begin
      if (cmd_q.op == OP_MASK_BIT_CLEAR) begin
         opb = 8'hFF - cmd_q.imm;
      end else if (cmd_q.op == OP_SELF_CONJUNCTION_CHECK) begin
         opb = opa;
      end else if (use_imm) begin
         opb = cmd_q.imm;
      end else begin
         opb = opr;
      end
   end

   abx_alu u_alu (
      .a(opa),
      .b(opb),
      .ci(use_c & flags_q[FLG_C]),
      .sel(alu_sel),
      .res(alu_res),
      .fl(alu_fl)
   );

   // Skip and jump conditions
   always_comb begin
      is_skip = 1'b1;
      is_jump = 1'b0;
      cond = 1'b0;
      case (cmd_q.op)
         OP_EQUAL_SKIP: cond = (opa == opr);
         OP_REGISTER_BIT_ZERO_SKIP: cond = ~opr[cmd_q.bit_idx];
         OP_REGISTER_BIT_ONE_SKIP: cond = opr[cmd_q.bit_idx];
         OP_IO_BIT_ZERO_SKIP: cond = ~io_q[cmd_q.bit_idx];
         OP_IO_BIT_ONE_SKIP: cond = io_q[cmd_q.bit_idx];
         OP_STATUS_BIT_ONE_JUMP: begin
            is_skip = 1'b0;
            is_jump = 1'b1;
            cond = flags_q[cmd_q.bit_idx];
         end
         OP_STATUS_BIT_ZERO_JUMP: begin
            is_skip = 1'b0;
            is_jump = 1'b1;
            cond = ~flags_q[cmd_q.bit_idx];
         end
         default: begin
            is_skip = 1'b0;
            is_jump = (cmd_q.op >= OP_EQUAL_JUMP) &&
                      (cmd_q.op <= OP_IRQ_DISABLED_JUMP);
            cond = jump_test(cmd_q.op, flags_q);
         end
      endcase
      taken = (is_skip | is_jump) & cond;
   end

   // signed word displacement from next word
   always_comb begin
      if (is_jump && cond) begin
         pc_next = pc_add(pc_add(pc_q, {{(PC_W - DISP_W){disp_q[DISP_W-1]}},
                                        disp_q}), 10'h001);
      end else if (is_skip && cond) begin
         pc_next = pc_add(pc_q, cmd_q.next_long ? 10'h003 : 10'h002);
      end else begin
         pc_next = pc_add(pc_q, 10'h001);
      end
   end

   // skips and jumps leave flags alone
   always_comb begin
      flags_next = flags_q;
      if (arith) begin
         flags_next[FLG_H] = alu_fl.h;
         flags_next[FLG_V] = alu_fl.v;
         flags_next[FLG_N] = alu_fl.n;
         flags_next[FLG_Z] = alu_fl.z;
         flags_next[FLG_C] = alu_fl.c;
      end else if (logic_op) begin
         flags_next[FLG_V] = 1'b0;
         flags_next[FLG_N] = alu_fl.n;
         flags_next[FLG_Z] = alu_fl.z;
      end
   end

   // one cycle, or two when taken
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= ST_IDLE;
         last_q <= 2'h0;
      end else if (CE) begin
         case (state_q)
            ST_IDLE: begin
               if (wr_go && !widx_q[IDX_RF_BIT] && widx_q == IDX_CMD) begin
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               state_q <= taken ? ST_HOLD : ST_IDLE;
               last_q <= taken ? CYC_TAKEN : CYC_PLAIN;
            end
            ST_HOLD: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Software loaded registers
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cmd_q <= '0;
         disp_q <= DISP_RST;
         io_q <= IO_RST;
      end else if (wr_go && !widx_q[IDX_RF_BIT]) begin
         case (widx_q)
            IDX_CMD: cmd_q <= abx_cmd_s'(HWDATA[27:0]);
            IDX_DISP: disp_q <= HWDATA[DISP_W-1:0];
            IDX_IO: io_q <= HWDATA[7:0];
            default: io_q <= io_q;
         endcase
      end
   end

   // Status register and program counter
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         flags_q <= FLAGS_RST;
         pc_q <= PC_RST;
      end else if (exec) begin
         flags_q <= flags_next;
         pc_q <= pc_next;
      end else if (wr_go && widx_q == IDX_FLAGS) begin
         flags_q <= HWDATA[7:0];
      end else if (wr_go && widx_q == IDX_PC) begin
         pc_q <= HWDATA[PC_W-1:0];
      end
   end

   // compares and tests skip the write back
   always_ff @(posedge CLK) begin
      if (exec && wb) begin
         rf_q[cmd_q.dst] <= alu_res;
      end else if (wr_go && widx_q[IDX_RF_BIT]) begin
         rf_q[widx_q[4:0]] <= HWDATA[7:0];
      end
   end

endmodule // abx_core

// ### core/abx_pkg.sv
// Shared constants and types for the ALU and branch execute block.
// Assumes a single 125 MHz core clock and an AHB-Lite register port.
package abx_pkg;

   localparam int DATA_W = 8;
   localparam int PC_W = 10;
   localparam int RF_N = 32;
   localparam int DISP_W = 7;

   // Clock figures
   localparam int CLK_PERIOD_NS = 8;
   localparam logic [1:0] CYC_PLAIN = 2'h1;
   localparam logic [1:0] CYC_TAKEN = 2'h2;

   // Word indices on the bus (byte address is four times the index)
   localparam logic [5:0] IDX_CMD = 6'h00;
   localparam logic [5:0] IDX_DISP = 6'h01;
   localparam logic [5:0] IDX_FLAGS = 6'h02;
   localparam logic [5:0] IDX_PC = 6'h03;
   localparam logic [5:0] IDX_STAT = 6'h04;
   localparam logic [5:0] IDX_IO = 6'h05;
   localparam int IDX_RF_BIT = 5;

   // Reset values
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 10'h000;
   localparam logic [7:0] IO_RST = 8'h00;
   localparam logic [DISP_W-1:0] DISP_RST = 7'h00;

   // Status register bit positions
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;

   // Status word field positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_LAST_LSB = 1;

   // Operation codes
   localparam logic [5:0] OP_ADD = 6'h00;
   localparam logic [5:0] OP_ADC = 6'h01;
   localparam logic [5:0] OP_SUB = 6'h02;
   localparam logic [5:0] OP_BORROW_REGISTER_DIFFERENCE = 6'h03;
   localparam logic [5:0] OP_IMMEDIATE_DIFFERENCE = 6'h04;
   localparam logic [5:0] OP_IMMEDIATE_BORROW_DIFFERENCE = 6'h05;
   localparam logic [5:0] OP_FLAG_ONLY_COMPARE = 6'h06;
   localparam logic [5:0] OP_CARRY_COMPARE = 6'h07;
   localparam logic [5:0] OP_IMMEDIATE_COMPARE = 6'h08;
   localparam logic [5:0] OP_AND = 6'h09;
   localparam logic [5:0] OP_CONSTANT_CONJUNCTION = 6'h0A;
   localparam logic [5:0] OP_OR = 6'h0B;
   localparam logic [5:0] OP_CONSTANT_DISJUNCTION = 6'h0C;
   localparam logic [5:0] OP_EXCLUSIVE_DISJUNCTION = 6'h0D;
   localparam logic [5:0] OP_MASK_BIT_CLEAR = 6'h0E;
   localparam logic [5:0] OP_MASK_BIT_SET = 6'h0F;
   localparam logic [5:0] OP_SELF_CONJUNCTION_CHECK = 6'h10;
   localparam logic [5:0] OP_EQUAL_SKIP = 6'h11;
   localparam logic [5:0] OP_REGISTER_BIT_ZERO_SKIP = 6'h12;
   localparam logic [5:0] OP_REGISTER_BIT_ONE_SKIP = 6'h13;
   localparam logic [5:0] OP_IO_BIT_ZERO_SKIP = 6'h14;
   localparam logic [5:0] OP_IO_BIT_ONE_SKIP = 6'h15;
   localparam logic [5:0] OP_STATUS_BIT_ONE_JUMP = 6'h16;
   localparam logic [5:0] OP_STATUS_BIT_ZERO_JUMP = 6'h17;
   localparam logic [5:0] OP_EQUAL_JUMP = 6'h18;
   localparam logic [5:0] OP_UNEQUAL_JUMP = 6'h19;
   localparam logic [5:0] OP_CARRY_ONE_JUMP = 6'h1A;
   localparam logic [5:0] OP_CARRY_ZERO_JUMP = 6'h1B;
   localparam logic [5:0] OP_UNSIGNED_GE_JUMP = 6'h1C;
   localparam logic [5:0] OP_UNSIGNED_LESS_JUMP = 6'h1D;
   localparam logic [5:0] OP_NEGATIVE_JUMP = 6'h1E;
   localparam logic [5:0] OP_POSITIVE_JUMP = 6'h1F;
   localparam logic [5:0] OP_SIGNED_GE_JUMP = 6'h20;
   localparam logic [5:0] OP_SIGNED_LESS_JUMP = 6'h21;
   localparam logic [5:0] OP_HALFCARRY_ONE_JUMP = 6'h22;
   localparam logic [5:0] OP_HALFCARRY_ZERO_JUMP = 6'h23;
   localparam logic [5:0] OP_COPYFLAG_ONE_JUMP = 6'h24;
   localparam logic [5:0] OP_COPYFLAG_ZERO_JUMP = 6'h25;
   localparam logic [5:0] OP_OVERFLOW_ONE_JUMP = 6'h26;
   localparam logic [5:0] OP_OVERFLOW_ZERO_JUMP = 6'h27;
   localparam logic [5:0] OP_IRQ_ENABLED_JUMP = 6'h28;
   localparam logic [5:0] OP_IRQ_DISABLED_JUMP = 6'h29;

   typedef enum logic [2:0] {
      ALU_ADD,
      ALU_SUB,
      ALU_AND,
      ALU_OR,
      ALU_XOR
   } abx_alusel_e;

   // Command word, bits 27:0 of the command register
   typedef struct packed {
      logic next_long;
      logic [2:0] bit_idx;
      logic [7:0] imm;
      logic [4:0] src;
      logic [4:0] dst;
      logic [5:0] op;
   } abx_cmd_s;

   typedef struct packed {
      logic h;
      logic v;
      logic n;
      logic z;
      logic c;
   } abx_flags_s;

endpackage

// ### tb/abx_monitor.sv
// Bus-port checker for the ALU and jump execute block.
// Assumes one slave: HREADY is the block's own HREADYOUT.
`timescale 1ns/1ns
module abx_monitor (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic [31:0] HRDATA,
   input wire logic HRESP
);
   import abx_pkg::*;
   logic dph_q, rd_q, first_q, taken, rd_done;
   logic [5:0] idx_q;
   logic [2:0] low_q;
   assign taken = CE & HREADY & HSEL & HTRANS[1];
   assign rd_done = dph_q & rd_q & HREADYOUT;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         dph_q <= 1'b0;
         rd_q <= 1'b0;
         first_q <= 1'b0;
         idx_q <= 6'h00;
      end else if (HREADY) begin
         dph_q <= taken;
         rd_q <= !HWRITE;
         first_q <= taken;
         idx_q <= HADDR[7:2];
      end else begin
         first_q <= 1'b0;
      end
   end
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B)
         low_q <= 3'h0;
      else if (!CE || HREADYOUT)
         low_q <= 3'h0;
      else if (low_q != 3'h7)
         low_q <= low_q + 3'h1;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   a_resp_okay: assert property (HRESP == 1'b0)
      else $error("response not okay");
   a_ce_stall: assert property (!CE |-> !HREADYOUT)
      else $error("ready while clock enable low");
   a_idle_ready: assert property (CE && !dph_q |-> HREADYOUT)
      else $error("not ready outside data phase");
   a_read_wait: assert property (first_q && rd_q |-> !HREADYOUT)
      else $error("read without its wait state");
   a_wait_bound: assert property (low_q <= 3'h3)
      else $error("too many wait states");
   a_upper_zero: assert property (
      rd_done && idx_q != IDX_CMD |-> HRDATA[31:10] == 22'h0)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (
      rd_done && idx_q inside {[6'h06:6'h1F]} |-> HRDATA == 32'h0)
      else $error("unmapped read not zero");
   a_stat_idle: assert property (
      rd_done && idx_q == IDX_STAT |-> !HRDATA[0] && HRDATA[2:1] != 2'h3)
      else $error("status read busy or bad count");
   a_rdata_hold: assert property (
      $changed(HRDATA) |-> $past(dph_q) && $past(rd_q) ||
      $past(taken) && !$past(HWRITE))
      else $error("read data moved without a read");
   cover property (rd_done && idx_q == IDX_STAT && HRDATA[2:1] == CYC_TAKEN);
   cover property (!CE ##1 CE);
   cover property (low_q == 3'h2);
endmodule // abx_monitor

// ### tb/alu_and_branch_execute_tb.sv
// Self-checking bench: AHB-Lite master, reference model, read checker.
// Assumes the execute block is the only slave on the bus.
`timescale 1ns/1ns
module alu_and_branch_execute_tb;
   import abx_pkg::*;
   logic CLK, RST_B, CE, HSEL, HWRITE, HREADYOUT, HRESP, rph, tk;
   logic [31:0] HADDR, HWDATA, HRDATA, st, v, w;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [5:0] op;
   logic [4:0] dst, src;
   logic [6:0] k7;
   logic [7:0] a, b, s, io;
   logic [9:0] cnt, nx;
   logic [16:0] r;
   logic [63:0] exp_q[$];
   int bad_count, cmp_count;
   abx_core dut (.CLK(CLK), .RST_B(RST_B), .CE(CE), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT),
      .HRDATA(HRDATA), .HRESP(HRESP));
   function automatic logic [31:0] rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   function automatic logic [16:0] alu_m(input logic [5:0] o,
         input logic [7:0] x, y0, kk, f);
      logic [7:0] y, q;
      logic c, h, ov, ci;
      ci = (o inside {6'h01, 6'h03, 6'h05, 6'h07}) & f[FLG_C];
      y = (o inside {6'h04, 6'h05, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h0F})
         ? kk : y0;
      if (o <= 6'h01) begin
         {c, q} = x + y + ci;
         h = x[3] & y[3] | y[3] & ~q[3] | ~q[3] & x[3];
         ov = x[7] & y[7] & ~q[7] | ~x[7] & ~y[7] & q[7];
      end else if (o <= 6'h08) begin
         {c, q} = {1'b0, x} - y - ci;
         h = ~x[3] & y[3] | y[3] & q[3] | q[3] & ~x[3];
         ov = x[7] & ~y[7] & ~q[7] | ~x[7] & y[7] & q[7];
      end else begin
         c = f[FLG_C];
         h = f[FLG_H];
         ov = 1'b0;
         q = (o == 6'h09 || o == 6'h0A) ? x & y : (o == 6'h0D) ? x ^ y :
            (o == 6'h0E) ? x & ~y : (o == 6'h10) ? x : x | y;
      end
      f[FLG_C] = c;
      f[FLG_Z] = (q == 8'h00);
      f[FLG_N] = q[7];
      f[FLG_V] = ov;
      f[FLG_H] = h;
      return {!(o inside {[6'h06:6'h08]}), q, f};
   endfunction
   function automatic logic jump_m(input logic [5:0] o,
         input logic [7:0] x, y, f, p, input logic [2:0] bi);
      logic [8:0] fb;
      logic [3:0] i;
      fb = {f[FLG_I], f[FLG_V], f[FLG_T], f[FLG_H], f[FLG_N] ^ f[FLG_V],
         f[FLG_N], f[FLG_C], f[FLG_C], f[FLG_Z]};
      i = 4'((o - 6'h18) >> 1);
      case (o)
         6'h11: return x == y;
         6'h12: return !y[bi];
         6'h13: return y[bi];
         6'h14: return !p[bi];
         6'h15: return p[bi];
         6'h16: return f[bi];
         6'h17: return !f[bi];
         default: return fb[i] == (!o[0] ^ (i == 4'h2 || i == 4'h4));
      endcase
   endfunction
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (HREADYOUT !== 1'b1 && n < 64);
      if (n >= 64) begin
         bad_count++;
         print_verdict();
      end
   endtask
   task automatic bus(input logic [5:0] idx, input logic wr_en,
         input logic [31:0] wd);
      HSEL <= 1'b1;
      HADDR <= {24'h000000, idx, 2'b00};
      HTRANS <= 2'h2;
      HWRITE <= wr_en;
      wait_rdy();
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      wait_rdy();
   endtask
   task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
      bus(idx, 1'b1, wd);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [31:0] ex,
         input logic [31:0] mk);
      exp_q.push_back({mk, ex});
      bus(idx, 1'b0, 32'h0);
   endtask
   task automatic check_rd();
      logic [63:0] e;
      e = exp_q.size() > 0 ? exp_q.pop_front() : {32'hFFFF_FFFF, ~HRDATA};
      cmp_count++;
      if ((HRDATA & e[63:32]) !== e[31:0]) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time,
            HRDATA & e[63:32], e[31:0]);
      end
   endtask
   always @(posedge CLK) begin
      if (rph && HREADYOUT === 1'b1)
         check_rd();
      if (HREADYOUT === 1'b1)
         rph <= HSEL && HTRANS[1] && !HWRITE && CE;
   end
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   initial begin
      #400000;
      bad_count++;
      print_verdict();
   end
   initial begin
      st = 32'h0000_003D;
      {RST_B, HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
      CE = 1'b1;
      HSIZE = 3'h2;
      bad_count = 0;
      cmp_count = 0;
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      @(posedge CLK);
      rd(IDX_FLAGS, 32'h0, '1);
      rd(IDX_PC, 32'h0, '1);
      rd(IDX_DISP, 32'h0, '1);
      rd(IDX_IO, 32'h0, '1);
      rd(IDX_STAT, 32'h0, 32'h1);
      wr(6'h06, rnd());
      CE <= 1'b0;
      repeat (3) @(posedge CLK);
      CE <= 1'b1;
      rd(6'h06, 32'h0, '1);
      $display("test reset done");
      cnt = 10'h000;
      for (int i = 0; i < 68; i++) begin
         op = 6'(i % 17);
         v = rnd();
         w = rnd();
         dst = w[4:0];
         src = (w[9:5] == dst) ? ~dst : w[9:5];
         wr({1'b1, dst}, {24'h0, v[7:0]});
         wr({1'b1, src}, {24'h0, v[15:8]});
         wr(IDX_FLAGS, {24'h0, v[31:24]});
         r = alu_m(op, v[7:0], v[15:8], v[23:16], v[31:24]);
         wr(IDX_CMD, {4'h0, 4'h0, v[23:16], src, dst, op});
         rd(IDX_STAT, {29'h0, CYC_PLAIN, 1'b0}, 32'h7);
         rd({1'b1, dst}, {24'h0, r[16] ? r[15:8] : v[7:0]}, '1);
         rd(IDX_FLAGS, {24'h0, r[7:0]}, '1);
         cnt = cnt + 10'h001;
         rd(IDX_PC, {22'h0, cnt}, '1);
      end
      $display("test alu done");
      for (int i = 0; i < 75; i++) begin
         op = 6'h11 + 6'(i % 25);
         v = rnd();
         w = rnd();
         a = v[7:0];
         b = w[10] ? a : v[15:8];
         s = v[23:16];
         io = v[31:24];
         k7 = w[17:11];
         cnt = w[29:20];
         wr(6'h22, {24'h0, a});
         wr(6'h27, {24'h0, b});
         wr(IDX_FLAGS, {24'h0, s});
         wr(IDX_IO, {24'h0, io});
         wr(IDX_DISP, {25'h0, k7});
         wr(IDX_PC, {22'h0, cnt});
         tk = jump_m(op, a, b, s, io, w[2:0]);
         if (!tk)
            nx = cnt + 10'h001;
         else if (op <= 6'h15)
            nx = cnt + (w[3] ? 10'h003 : 10'h002);
         else
            nx = cnt + {{3{k7[6]}}, k7} + 10'h001;
         wr(IDX_CMD, {4'h0, w[3], w[2:0], 8'h00, 5'h07, 5'h02, op});
         rd(IDX_STAT, {29'h0, tk ? CYC_TAKEN : CYC_PLAIN, 1'b0}, 32'h7);
         rd(IDX_PC, {22'h0, nx}, '1);
         rd(IDX_FLAGS, {24'h0, s}, '1);
      end
      $display("test jump done");
      repeat (4) @(posedge CLK);
      print_verdict();
   end
endmodule // alu_and_branch_execute_tb
bind abx_core abx_monitor u_mon (.CLK(CLK), .RST_B(RST_B), .CE(CE),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP));
